// >>> design/ssc_pkg.sv
// Purpose: Constants and carriers for the synchronous serial channel.
// Assumes: 40 MHz system clock; registers reached over a plain strobe port.
// Notes:   Register offsets are word indices on the plain port.
package ssc_pkg;
  localparam logic [2:0]  ADDR_CTRL   = 3'h0;
  localparam logic [2:0]  ADDR_RELOAD = 3'h1;
  localparam logic [2:0]  ADDR_TXDATA = 3'h2;
  localparam logic [2:0]  ADDR_RXDATA = 3'h3;
  localparam logic [2:0]  ADDR_STATUS = 3'h4;
  // Control register fields.
  localparam int          CTRL_ENABLE = 15;
  localparam int          CTRL_MASTER = 14;
  localparam int          CTRL_HALFDX = 8;
  localparam int          CTRL_PHASE  = 6;
  localparam int          CTRL_POL    = 5;
  localparam int          CTRL_LSBF   = 4;
  localparam int          CTRL_WLO    = 0;
  localparam int          WIDTH_BITS  = 4;
  localparam logic [15:0] CTRL_RESET  = 16'h0007;
  localparam logic [15:0] RELOAD_RESET = 16'h0001;
  localparam logic        PRESCALE_MAX = 1'b1;

  typedef struct packed {
    logic       enable;
    logic       master;
    logic       half_duplex;
    logic       phase;
    logic       polarity;
    logic       lsb_first;
    logic [3:0] width_m1;
  } ctrl_s;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic mosi_oe;
    logic sclk_oe;
  } link_out_s;
endpackage

// >>> design/ssc_fifo.sv
`timescale 1ns/10ps
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: One clock, asynchronous active high reset.
// Notes:   Depth must be a power of two.
module ssc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_i,    // System clock.
  input  wire logic             rst_i,     // Asynchronous reset.
  input  wire logic [WIDTH-1:0] in_data_i, // Write data.
  input  wire logic             in_valid_i,// Write request.
  output logic                  in_ready_o,// Not full.
  output logic [WIDTH-1:0]      out_data_o,// Head word.
  output logic                  out_valid_o,// Not empty.
  input  wire logic             out_ready_i // Pop request.
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic [AW:0]      next_wptr;
  logic [AW:0]      next_rptr;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready_o  = (wptr - rptr) != (AW+1)'(DEPTH);
    out_valid_o = wptr != rptr;
    push        = in_valid_i && in_ready_o;
    pop         = out_ready_i && out_valid_o;
    next_wptr   = push ? wptr + 1'b1 : wptr;
    next_rptr   = pop ? rptr + 1'b1 : rptr;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr       <= '0;
      rptr       <= '0;
      out_data_o <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      if (push) begin
        mem[wptr[AW-1:0]] <= in_data_i;
      end
      out_data_o <= mem[next_rptr[AW-1:0]];
      if (push && (next_rptr == wptr)) begin
        out_data_o <= in_data_i;
      end
    end
  end
endmodule

// >>> design/sync_serial_channel.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
// Purpose: Synchronous serial channel with its own down-counting baud generator.
// Assumes: Pins arrive asynchronously; software keeps the reload nonzero.
// Notes:   Transmit side holds an 8-word FIFO ahead of the shift register.
module sync_serial_channel
  import ssc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                mclk_i,    // 40 MHz system clock.
  input  wire logic                rst_i,     // Asynchronous reset, high.
  input  wire logic [2:0]          addr_i,    // Register word index.
  input  wire logic [15:0]         wdata_i,   // Write data.
  input  wire logic                wr_i,      // Write strobe.
  input  wire logic                rd_i,      // Read strobe.
  output logic [15:0]              rdata_o,   // Read data, cycle after rd_i.
  input  wire logic                sclk_i,    // Shift clock pin in.
  input  wire logic                miso_i,    // Serial data in.
  output ssc_pkg::link_out_s       link_o     // Clock and data pins out.
);
  import ssc_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] sclk_sync;
  logic [1:0] miso_sync;
  logic       sclk_last;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_sync <= '0;
      miso_sync <= '0;
      sclk_last <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk_i};
      miso_sync <= {miso_sync[0], miso_i};
      sclk_last <= sclk_sync[1];
    end
  end

  // ==========================================================
  // Registers
  ctrl_s       ctrl;
  logic [15:0] ctrl_word;
  logic [15:0] reload;
  logic [15:0] next_ctrl_word;
  logic [15:0] next_reload;
  logic [15:0] rx_hold;
  logic        rx_full;
  logic        rx_overrun;
  logic [15:0] count;
  logic        busy;
  logic        fifo_in_ready;
  logic [15:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;

  always_comb begin
    ctrl.enable      = ctrl_word[CTRL_ENABLE];
    ctrl.master      = ctrl_word[CTRL_MASTER];
    ctrl.half_duplex = ctrl_word[CTRL_HALFDX];
    ctrl.phase       = ctrl_word[CTRL_PHASE];
    ctrl.polarity    = ctrl_word[CTRL_POL];
    ctrl.lsb_first   = ctrl_word[CTRL_LSBF];
    ctrl.width_m1    = ctrl_word[CTRL_WLO +: WIDTH_BITS];
    next_ctrl_word   = ctrl_word;
    next_reload      = reload;
    if (wr_i && addr_i == ADDR_CTRL) begin
      next_ctrl_word = wdata_i;
    end
    if (wr_i && addr_i == ADDR_RELOAD && !ctrl.enable) begin
      next_reload = wdata_i;
    end
  end

  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL:   next_rdata = ctrl_word;
        ADDR_RELOAD: next_rdata = ctrl.enable ? count : reload;
        ADDR_RXDATA: next_rdata = rx_hold;
        ADDR_STATUS: next_rdata = {12'h000, rx_overrun, rx_full, busy, fifo_in_ready};
        default:     next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_word <= CTRL_RESET;
      reload    <= RELOAD_RESET;
      rdata_o   <= 16'h0000;
    end else begin
      ctrl_word <= next_ctrl_word;
      reload    <= next_reload;
      rdata_o   <= next_rdata;
    end
  end

  // ==========================================================
  // Transmit buffer: software writes land here while a shift runs.
  ssc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_data_i   (wdata_i),
    .in_valid_i  (wr_i && addr_i == ADDR_TXDATA),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // ==========================================================
  // Baud generator: half-rate prescaler then 16-bit down counter.
  logic        prescale;
  logic        next_prescale;
  logic [15:0] mid_count;
  logic        load_word;
  logic [15:0] next_count;
  logic        half_tick;
  always_comb begin
    next_prescale = 1'b0;
    next_count    = count;
    half_tick     = 1'b0;
    mid_count     = 16'(({1'b0, reload} + 17'h00001) >> 1);
    load_word     = ctrl.enable && !busy && fifo_valid;
    // A new word restarts the timer, so its first edge is a full half bit away.
    if (!ctrl.enable || load_word) begin
      next_count = reload;
    end else begin
      next_prescale = prescale ^ 1'b1;
      // Underflow ends a bit; the matching mid-count phase splits it in halves.
      if (prescale == reload[0] && count == mid_count) begin
        half_tick = 1'b1;
      end
      if (prescale == PRESCALE_MAX) begin
        if (count == 16'h0000) begin
          next_count = reload;
          half_tick  = 1'b1;
        end else begin
          next_count = count - 16'h0001;
        end
      end
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prescale <= 1'b0;
      count    <= RELOAD_RESET;
    end else begin
      prescale <= next_prescale;
      count    <= next_count;
    end
  end

  // ==========================================================
  // Shift engine. A shift edge and a sample edge alternate each half bit.
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic [15:0] rxreg;
  logic [15:0] next_rxreg;
  logic [4:0]  edges;
  logic [4:0]  next_edges;
  logic        sclk_int;
  logic        next_sclk_int;
  logic        next_busy;
  logic [15:0] next_rx_hold;
  logic        next_rx_full;
  logic        next_rx_overrun;
  logic        lead_edge;
  logic        trail_edge;
  logic        sample_now;
  logic        shift_now;
  logic        in_bit;
  logic        out_bit;
  logic        sclk_rise;
  logic        sclk_fall;

  always_comb begin
    sclk_rise  = sclk_sync[1] && !sclk_last;
    sclk_fall  = !sclk_sync[1] && sclk_last;
    // Slave edges come from the external master, master edges from the timer.
    lead_edge  = ctrl.master ? (half_tick && !sclk_int) : (ctrl.polarity ? sclk_fall : sclk_rise);
    trail_edge = ctrl.master ? (half_tick && sclk_int)  : (ctrl.polarity ? sclk_rise : sclk_fall);
    sample_now = busy && (ctrl.phase ? trail_edge : lead_edge);
    shift_now  = busy && (ctrl.phase ? lead_edge : trail_edge);
    in_bit     = miso_sync[1];
    out_bit    = ctrl.lsb_first ? shreg[0] : shreg[ctrl.width_m1];
    fifo_pop   = 1'b0;
    next_shreg = shreg;
    next_rxreg = rxreg;
    next_edges = edges;
    next_busy  = busy;
    next_sclk_int = sclk_int;
    next_rx_hold  = rx_hold;
    next_rx_full  = rx_full && !(rd_i && addr_i == ADDR_RXDATA);
    next_rx_overrun = rx_overrun && !(wr_i && addr_i == ADDR_STATUS);
    if (!ctrl.enable) begin
      next_busy     = 1'b0;
      next_sclk_int = 1'b0;
    end else if (!busy) begin
      if (fifo_valid) begin
        fifo_pop   = 1'b1;
        next_shreg = fifo_data;
        next_rxreg = 16'h0000;
        next_busy  = 1'b1;
        next_edges = 5'h00;
      end
    end else begin
      if (ctrl.master && half_tick) begin
        next_sclk_int = !sclk_int;
      end
      // With late phase the first bit is already out, so the first lead edge keeps it.
      if (shift_now && !(ctrl.phase && edges == 5'h00)) begin
        if (ctrl.lsb_first) begin
          next_shreg = {1'b0, shreg[15:1]};
        end else begin
          next_shreg = {shreg[14:0], 1'b0};
        end
      end
      // Received bits go to their own register so no unsent bit is overwritten.
      if (sample_now) begin
        if (ctrl.lsb_first) begin
          next_rxreg = {1'b0, rxreg[15:1]};
          next_rxreg[ctrl.width_m1] = in_bit;
        end else begin
          next_rxreg = {rxreg[14:0], in_bit};
        end
      end
      if (lead_edge || trail_edge) begin
        next_edges = edges + 5'h01;
        if (edges == {ctrl.width_m1, 1'b1}) begin
          next_busy = 1'b0;
          if (!ctrl.half_duplex || !ctrl.master) begin
            next_rx_hold    = next_rxreg;
            next_rx_overrun = next_rx_overrun || rx_full;
            next_rx_full    = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      shreg      <= 16'h0000;
      rxreg      <= 16'h0000;
      edges      <= 5'h00;
      busy       <= 1'b0;
      sclk_int   <= 1'b0;
      rx_hold    <= 16'h0000;
      rx_full    <= 1'b0;
      rx_overrun <= 1'b0;
      link_o     <= '0;
    end else begin
      shreg      <= next_shreg;
      rxreg      <= next_rxreg;
      edges      <= next_edges;
      busy       <= next_busy;
      sclk_int   <= next_sclk_int;
      rx_hold    <= next_rx_hold;
      rx_full    <= next_rx_full;
      rx_overrun <= next_rx_overrun;
      link_o.sclk    <= sclk_int ^ ctrl.polarity;
      link_o.sclk_oe <= ctrl.enable && ctrl.master;
      link_o.mosi    <= out_bit;
      link_o.mosi_oe <= ctrl.enable && (ctrl.master || busy);
    end
  end
endmodule

// >>> sim/ssc_assertions.sv
`timescale 1ns/10ps
// Purpose: Port-level checks of the serial channel.
// Assumes: Register writes take effect on the edge after the strobe.
// Notes:   Control and reload shadows are rebuilt from the write port.
module ssc_assertions
  import ssc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic               mclk_i,  // Clock.
  input wire logic               rst_i,   // Reset.
  input wire logic [2:0]         addr_i,  // Address.
  input wire logic [15:0]        wdata_i, // Write data.
  input wire logic               wr_i,    // Write strobe.
  input wire logic               rd_i,    // Read strobe.
  input wire logic [15:0]        rdata_o, // Read data.
  input wire logic               sclk_i,  // Clock in.
  input wire logic               miso_i,  // Data in.
  input wire ssc_pkg::link_out_s link_o   // Pins out.
);
  logic [15:0] ctl, rl, gap, next_ctl, next_rl, next_gap;
  logic        sq, armed, next_armed;
  always_comb begin
    next_ctl = (wr_i && addr_i == ADDR_CTRL) ? wdata_i : ctl;
    next_rl = (wr_i && addr_i == ADDR_RELOAD && !ctl[CTRL_ENABLE]) ? wdata_i : rl;
    next_gap = (link_o.sclk != sq) ? 16'h0 : gap + 16'(gap != 16'hffff);
    next_armed = ctl[CTRL_ENABLE] && ctl[CTRL_MASTER] && (armed || link_o.sclk != sq);
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl <= CTRL_RESET;
      rl <= RELOAD_RESET;
      gap <= 16'h0;
      sq <= 1'b0;
      armed <= 1'b0;
    end else begin
      ctl <= next_ctl;
      rl <= next_rl;
      gap <= next_gap;
      sq <= link_o.sclk;
      armed <= next_armed;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_rd_idle; !rd_i |=> rdata_o == 16'h0; endproperty
  property p_ctl_back;
    rd_i && addr_i == ADDR_CTRL |=> (rdata_o & 16'hc17f) == (ctl & 16'hc17f);
  endproperty
  property p_rl_off; rd_i && addr_i == ADDR_RELOAD && !ctl[CTRL_ENABLE] |=> rdata_o == rl;
  endproperty
  property p_rl_on; rd_i && addr_i == ADDR_RELOAD && ctl[CTRL_ENABLE] |=> rdata_o <= rl;
  endproperty
  property p_stop; !ctl[CTRL_ENABLE] && !wr_i && !$past(wr_i) |=> $stable(link_o.sclk);
  endproperty
  property p_slave_oe; !ctl[CTRL_MASTER] && !$past(ctl[CTRL_MASTER]) |-> !link_o.sclk_oe;
  endproperty
  property p_gap; armed && link_o.sclk != sq |-> gap >= rl; endproperty
  property p_ovr_clr;
    wr_i && addr_i == ADDR_STATUS ##2 rd_i && addr_i == ADDR_STATUS |=> !rdata_o[3];
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_ctl_back: assert property (p_ctl_back) else $error("control readback");
  a_rl_off: assert property (p_rl_off) else $error("reload readback");
  a_rl_on: assert property (p_rl_on) else $error("live count above reload");
  a_stop: assert property (p_stop) else $error("clock moves while off");
  a_slave_oe: assert property (p_slave_oe) else $error("slave drives clock");
  a_gap: assert property (p_gap) else $error("half period too short");
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");
  c_toggle: cover property (armed && link_o.sclk != sq);
  c_rx_read: cover property (rd_i && addr_i == ADDR_RXDATA);
  c_refused: cover property (wr_i && addr_i == ADDR_RELOAD && ctl[CTRL_ENABLE]);
endmodule

bind sync_serial_channel ssc_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.mclk_i(mclk_i),
  .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .sclk_i(sclk_i), .miso_i(miso_i), .link_o(link_o));

// >>> sim/spi_peripheral_model.sv
`timescale 1ns/10ps
// Purpose: Far-side peripheral that echoes the channel's data inverted.
// Assumes: Data line has no pull; a released line shows a toggling pattern.
// Notes:   DLY sets how slowly the answer follows the pins.
module spi_peripheral_model
  import ssc_pkg::*;
#(
  parameter int DLY = 3
) (
  input  wire logic               mclk_i, // Clock for the idle pattern.
  input  wire ssc_pkg::link_out_s link_i, // Pins from the channel.
  output wire logic               miso_o  // Data back.
);
  logic junk = 1'b0;
  always @(posedge mclk_i) junk <= ~junk;
  // Inversion tells a looped-back word apart from a line stuck at the sent value.
  assign #DLY miso_o = link_i.mosi_oe ? ~link_i.mosi : junk;
endmodule

// >>> sim/sync_serial_channel_tb_top.sv
`timescale 1ns/10ps
// Purpose: Self-checking bench for the serial channel.
// Assumes: Inverting echo peripheral on the data lines; master mode only.
// Notes:   Received words are predicted from a queue of sent words.
module sync_serial_channel_tb_top;
  import ssc_pkg::*;
  logic        mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sclk_i = 0, sq = 0;
  logic [2:0]  addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o;
  logic [31:0] seed = 32'd88978;
  wire         miso_i;
  link_out_s   link_o;
  int          n_mismatch = 0, checks = 0, cyc = 0, tq[$], exp_q[$];
  sync_serial_channel #(.FIFO_DEPTH(8)) uut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_i(sclk_i),
    .miso_i(miso_i), .link_o(link_o));
  spi_peripheral_model #(.DLY(3)) peer (.mclk_i(mclk_i), .link_i(link_o), .miso_o(miso_i));
  initial forever #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    sq <= link_o.sclk;
    if (link_o.sclk !== sq) tq.push_back(cyc);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge mclk_i);
  endtask
  task automatic wait_bit(input int b, input logic v);
    logic [15:0] s;
    for (int k = 0; k < 1500; k++) begin
      rd(ADDR_STATUS, s);
      if (s[b] === v) break;
    end
    check({15'h0, s[b]}, {15'h0, v});
  endtask
  task automatic wait_tog(input int n);
    for (int k = 0; k < 4000 && tq.size() < n; k++) @(posedge mclk_i);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    logic [15:0] d, c;
    logic [3:0]  wm;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(ADDR_CTRL, d);
    check(d, CTRL_RESET);
    rd(ADDR_RELOAD, d);
    check(d, RELOAD_RESET);
    wr(3'h7, 16'hffff);
    rd(ADDR_CTRL, d);
    check(d, CTRL_RESET);
    wr(ADDR_RELOAD, 16'h0040);
    wr(ADDR_CTRL, 16'hc007);
    wr(ADDR_RELOAD, 16'h0003);
    rd(ADDR_RELOAD, d);
    check({15'h0, d <= 16'h0040}, 16'h1);
    wr(ADDR_CTRL, 16'h4007);
    rd(ADDR_RELOAD, d);
    check(d, 16'h0040);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wm = 4'(3 + seed[19:16] % 13);
      c = {7'h0, i == 5, 1'b0, seed[6:4], wm};
      wr(ADDR_RELOAD, 16'(3 + i % 3));
      wr(ADDR_TXDATA, seed[15:0]);
      wr(ADDR_CTRL, c | 16'h4000);
      // Let a polarity change reach the pin before toggles are counted.
      repeat (2) @(posedge mclk_i);
      tq.delete();
      wr(ADDR_CTRL, c | 16'hc000);
      if (i != 5) exp_q.push_back(~seed[15:0] & 16'((32'h1 << (int'(wm) + 1)) - 1));
      wait_tog(2 * (int'(wm) + 1));
      wait_bit(1, 1'b0);
      check(16'(tq.size()), 16'(2 * (int'(wm) + 1)));
      for (int j = 1; j < tq.size(); j++) begin
        check(16'(tq[j] - tq[j - 1]), 16'(4 + i % 3));
      end
      if (i != 5) begin
        rd(ADDR_RXDATA, d);
        check(d, 16'(exp_q.pop_front()));
      end else begin
        rd(ADDR_STATUS, d);
        check({15'h0, d[2]}, 16'h0);
      end
      wr(ADDR_CTRL, c | 16'h4000);
    end
    $display("test transfers done");
    wr(ADDR_RELOAD, 16'h0001);
    wr(ADDR_CTRL, 16'h4007);
    for (int j = 0; j < 9; j++) begin
      rd(ADDR_STATUS, d);
      check({15'h0, d[0]}, {15'h0, j < 8});
      seed = lfsr(seed);
      wr(ADDR_TXDATA, seed[15:0]);
    end
    tq.delete();
    wr(ADDR_CTRL, 16'hc007);
    wait_tog(128);
    wait_bit(1, 1'b0);
    check(16'(tq.size()), 16'd128);
    rd(ADDR_STATUS, d);
    check({14'h0, d[3:2]}, 16'h3);
    wr(ADDR_STATUS, 16'h0);
    rd(ADDR_STATUS, d);
    check({15'h0, d[3]}, 16'h0);
    rd(ADDR_RXDATA, d);
    $display("test buffering done");
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_mismatch++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
